// [hdl/tta_acq_core.sv]
`timescale 1ns/1ps
module tta_acq_core #(
    parameter int SAMPLE_W = tta_pkg::SAMPLE_W,
    parameter int HIST_DEPTH = tta_pkg::HIST_DEPTH,
    parameter int FIFO_DEPTH = tta_pkg::FIFO_DEPTH
) (
    // clocking
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // converter samples
    input wire logic in_valid,
    input wire logic [SAMPLE_W-1:0] in_sample,
    input wire logic [SAMPLE_W-1:0] cha_sample,
    // correction, filter and skip
    input wire logic [15:0] gain,
    input wire logic signed [15:0] offset,
    input wire logic [tta_pkg::TAPS-1:0][tta_pkg::COEF_W-1:0] coef,
    input wire logic [15:0] skip,
    // trigger setup
    input wire tta_pkg::tta_trig_src_t trig_sel,
    input wire logic trig_falling,
    input wire logic [SAMPLE_W-1:0] level_thr,
    input wire logic [SAMPLE_W-1:0] cha_thr,
    input wire logic sw_trig,
    input wire logic star_trig,
    // acquisition control
    input wire logic start,
    input wire logic stop,
    input wire logic [31:0] rec_len,
    input wire logic [31:0] pre_len,
    input wire logic [31:0] trig_delay,
    input wire logic [31:0] rec_count,
    // sync pin
    input wire tta_pkg::tta_sync_mode_t sync_mode,
    input wire logic sync_in,
    output logic sync_out,
    output logic sync_oe_n,
    // record stream
    output logic rec_valid,
    input wire logic rec_ready,
    output logic [tta_pkg::WORD_W-1:0] rec_data,
    // status
    output logic busy,
    output logic done,
    output logic overflow,
    output logic [tta_pkg::TS_W-1:0] timestamp,
    output logic [tta_pkg::TS_W-1:0] trig_ts,
    output logic [tta_pkg::FRAC_W-1:0] trig_frac
);
    import tta_pkg::*;
    localparam int AW = $clog2(HIST_DEPTH);

    if (HIST_DEPTH < 4 || (1 << AW) != HIST_DEPTH || SAMPLE_W < 2 || SAMPLE_W > 30
        || INTERP_STEPS > 256 || TAPS < 2) begin : g_bad_param
        $error("unsupported history depth, sample width or interpolation steps");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [SAMPLE_W-1:0] corr;
        logic corr_v;
        logic [TAPS-1:0][SAMPLE_W-1:0] taps;
        logic [SAMPLE_W-1:0] filt;
        logic filt_v;
        logic [15:0] skip_cnt;
        logic [SAMPLE_W-1:0] kept;
        logic kept_v;
        logic [SAMPLE_W-1:0] prev_lvl;
        logic [SAMPLE_W-1:0] prev_a;
        logic prev_star;
        logic prev_sync;
        logic [TS_W-1:0] ts;
        logic [TS_W-1:0] ts_latch;
        logic [FRAC_W-1:0] frac;
        tta_state_t state;
        logic [31:0] delay_cnt;
        logic [31:0] rec_left;
        logic [31:0] samp_left;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [7:0] sync_cnt;
        logic stop_req;
        logic done;
        logic overflow;
    } tta_core_state_t;

    tta_core_state_t s;
    tta_core_state_t next_s;
    logic [SAMPLE_W-1:0] ring [HIST_DEPTH];
    logic push_valid;
    logic push_ready;
    logic [WORD_W-1:0] push_data;
    logic hit;
    logic hit_cha;
    logic trig_accept;
    logic store_now;
    logic [AW-1:0] pre_eff;
    logic [AW-1:0] lag;

    // ----------------------------------------
    // functions
    // ----------------------------------------
    function automatic logic [SAMPLE_W-1:0] sat(input logic signed [47:0] v);
        logic signed [47:0] hi;
        hi = (48'sd1 <<< (SAMPLE_W - 1)) - 48'sd1;
        if (v > hi) begin
            sat = hi[SAMPLE_W-1:0];
        end else if (v < -hi - 48'sd1) begin
            sat = ~hi[SAMPLE_W-1:0];
        end else begin
            sat = v[SAMPLE_W-1:0];
        end
    endfunction : sat

    function automatic logic crossing(input logic signed [SAMPLE_W-1:0] p,
                                      input logic signed [SAMPLE_W-1:0] c,
                                      input logic signed [SAMPLE_W-1:0] t,
                                      input logic fall);
        crossing = fall ? (p > t && c <= t) : (p < t && c >= t);
    endfunction : crossing

    function automatic logic [FRAC_W-1:0] interp(input logic signed [SAMPLE_W-1:0] p,
                                                 input logic signed [SAMPLE_W-1:0] c,
                                                 input logic signed [SAMPLE_W-1:0] t);
        logic signed [SAMPLE_W+1:0] num;
        logic signed [SAMPLE_W+1:0] den;
        logic [SAMPLE_W+9:0] q;
        num = (SAMPLE_W+2)'(t) - (SAMPLE_W+2)'(p);
        den = (SAMPLE_W+2)'(c) - (SAMPLE_W+2)'(p);
        q = '0;
        if (num < 0) begin
            num = -num;
        end
        if (den < 0) begin
            den = -den;
        end
        if (den != 0) begin
            q = ((SAMPLE_W+10)'(unsigned'(num)) * (SAMPLE_W+10)'(INTERP_STEPS))
                / (SAMPLE_W+10)'(unsigned'(den));
        end
        if (q > (SAMPLE_W+10)'(INTERP_STEPS - 1)) begin
            q = (SAMPLE_W+10)'(INTERP_STEPS - 1);
        end
        interp = q[FRAC_W-1:0];
    endfunction : interp

    tta_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_data),
        .out_valid(rec_valid),
        .out_ready(rec_ready),
        .out_data(rec_data)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic [SAMPLE_W-1:0] wr_sample;
        logic [TAPS-1:0][SAMPLE_W-1:0] sh;
        logic signed [47:0] acc;
        logic [31:0] pre_cap;
        logic last;
        wr_sample = '0;
        sh = {s.taps[TAPS-2:0], s.corr};
        acc = '0;
        last = 1'b0;
        next_s = s;
        push_valid = 1'b0;
        push_data = '0;
        store_now = 1'b0;
        hit = 1'b0;
        lag = s.wr - s.rd;
        pre_cap = pre_len;
        if (pre_cap > rec_len) begin
            pre_cap = rec_len;
        end
        if (pre_cap > 32'(HIST_DEPTH - 1)) begin
            pre_cap = 32'(HIST_DEPTH - 1);
        end
        pre_eff = pre_cap[AW-1:0];
        // correction, filter and skip
        next_s.corr_v = in_valid;
        if (in_valid) begin
            next_s.corr = sat(((48'(signed'(in_sample)) * 48'(signed'({1'b0, gain})))
                >>> GAIN_FRAC) + 48'(offset));
        end
        next_s.filt_v = s.corr_v;
        if (s.corr_v) begin
            next_s.taps = sh;
            for (int i = 0; i < TAPS; i++) begin
                acc = acc + 48'(signed'(sh[i])) * 48'(signed'(coef[i]));
            end
            next_s.filt = sat(acc >>> GAIN_FRAC);
        end
        next_s.kept_v = 1'b0;
        if (s.filt_v) begin
            if (s.skip_cnt == 16'h0000) begin
                next_s.kept = s.filt;
                next_s.kept_v = 1'b1;
                next_s.skip_cnt = skip;
            end else begin
                next_s.skip_cnt = s.skip_cnt - 16'h0001;
            end
        end
        if (s.kept_v) begin
            next_s.wr = s.wr + 1'b1;
            next_s.prev_lvl = s.kept;
        end
        // trigger sources
        hit_cha = in_valid && crossing(s.prev_a, cha_sample, cha_thr, trig_falling);
        if (in_valid) begin
            next_s.prev_a = cha_sample;
        end
        next_s.prev_star = star_trig;
        unique case (trig_sel)
            TRIG_SW: hit = sw_trig;
            TRIG_CHA: hit = hit_cha;
            TRIG_STAR: hit = star_trig && !s.prev_star;
            TRIG_LEVEL: hit = s.kept_v && crossing(s.prev_lvl, s.kept, level_thr,
                trig_falling);
        endcase
        trig_accept = (s.state == ST_ARMED) && hit && !stop;
        // time-stamp and sync pin
        next_s.ts = s.ts + 1'b1;
        next_s.prev_sync = sync_in;
        if (sync_mode == SYNC_IN && sync_in && !s.prev_sync) begin
            next_s.ts = '0;
        end
        if (s.sync_cnt != 8'h00) begin
            next_s.sync_cnt = s.sync_cnt - 8'h01;
        end
        // acquisition sequence
        unique case (s.state)
            ST_IDLE: begin
                if (start) begin
                    next_s.state = ST_ARMED;
                    next_s.rec_left = rec_count;
                    next_s.done = 1'b0;
                    next_s.overflow = 1'b0;
                end
            end
            ST_ARMED: begin
                if (stop) begin
                    next_s.state = ST_IDLE;
                end else if (trig_accept) begin
                    next_s.ts_latch = s.ts;
                    next_s.frac = (trig_sel == TRIG_CHA) ?
                        interp(s.prev_a, cha_sample, cha_thr) : '0;
                    next_s.samp_left = (rec_len == 32'h0000_0000) ? 32'h0000_0001 : rec_len;
                    if (sync_mode == SYNC_OUT) begin
                        next_s.sync_cnt = 8'(SYNC_PULSE_CYC);
                    end
                    if (trig_delay != 32'h0000_0000) begin
                        next_s.delay_cnt = trig_delay;
                        next_s.state = ST_DELAY;
                    end else begin
                        store_now = 1'b1;
                    end
                end
            end
            ST_DELAY: begin
                if (stop) begin
                    next_s.state = ST_IDLE;
                end else if (s.kept_v) begin
                    if (s.delay_cnt == 32'h0000_0001) begin
                        store_now = 1'b1;
                    end else begin
                        next_s.delay_cnt = s.delay_cnt - 32'h0000_0001;
                    end
                end
            end
            ST_HDR_TS: begin
                push_valid = 1'b1;
                push_data = {1'b1, s.ts_latch};
                if (push_ready) begin
                    next_s.state = ST_HDR_FR;
                end
            end
            ST_HDR_FR: begin
                push_valid = 1'b1;
                push_data = {1'b1, (TS_W - FRAC_W)'(0), s.frac};
                if (push_ready) begin
                    next_s.state = ST_CAPTURE;
                end
            end
            ST_CAPTURE: begin
                if (s.rd != s.wr) begin
                    wr_sample = ring[s.rd];
                    push_valid = 1'b1;
                    push_data = {1'b0, TS_W'(signed'(wr_sample))};
                    if (push_ready) begin
                        next_s.rd = s.rd + 1'b1;
                        next_s.samp_left = s.samp_left - 32'h0000_0001;
                        if (s.samp_left == 32'h0000_0001) begin
                            last = (rec_count != 32'h0000_0000) && (s.rec_left == 32'h0000_0001);
                            if (rec_count != 32'h0000_0000) begin
                                next_s.rec_left = s.rec_left - 32'h0000_0001;
                            end
                            next_s.state = (last || s.stop_req || stop) ? ST_IDLE : ST_ARMED;
                            next_s.done = last;
                            next_s.stop_req = 1'b0;
                        end
                    end
                end
            end
            default: next_s.state = ST_IDLE;
        endcase
        if ((s.state == ST_HDR_TS || s.state == ST_HDR_FR || s.state == ST_CAPTURE)
            && stop && next_s.state != ST_IDLE) begin
            next_s.stop_req = 1'b1;
        end
        if (store_now) begin
            next_s.state = ST_HDR_TS;
            next_s.rd = next_s.wr - pre_eff;
        end
        if (s.kept_v && s.state inside {ST_HDR_TS, ST_HDR_FR, ST_CAPTURE}
            && lag == AW'(HIST_DEPTH - 1) && next_s.rd == s.rd) begin
            next_s.overflow = 1'b1;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    always_ff @(posedge clock) begin
        if (ce && s.kept_v) begin
            ring[s.wr] <= s.kept;
        end
    end

    assign sync_out = s.sync_cnt != 8'h00;
    assign sync_oe_n = sync_mode != SYNC_OUT;
    assign busy = s.state != ST_IDLE;
    assign done = s.done;
    assign overflow = s.overflow;
    assign timestamp = s.ts;
    assign trig_ts = s.ts_latch;
    assign trig_frac = s.frac;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst || !ce);

    sequence seq_sync_pulse;
        sync_out [*4] ##1 !sync_out;
    endsequence

    chk_level_fire: assert property (s.state == ST_ARMED && trig_sel == TRIG_LEVEL && hit
        && !stop |=> s.state != ST_ARMED && s.state != ST_IDLE)
        else $error("level crossing did not start a record");
    chk_delay_exit: assert property (s.state == ST_DELAY && s.kept_v
        && s.delay_cnt == 32'h0000_0001 && !stop |=> s.state == ST_HDR_TS && push_valid)
        else $error("trigger delay did not end on its count");
    chk_pre_gap: assert property ($rose(s.state == ST_HDR_TS) |-> lag == $past(pre_eff))
        else $error("pre-trigger history gap is wrong");
    chk_sync_clear: assert property (sync_mode == SYNC_IN && sync_in && !s.prev_sync
        |=> timestamp == '0)
        else $error("sync input edge did not clear time-stamp");
    chk_sync_pulse: assert property (trig_accept && sync_mode == SYNC_OUT
        |=> seq_sync_pulse)
        else $error("sync output pulse has the wrong length");
    chk_ts_latch: assert property (trig_accept |=> trig_ts == $past(timestamp))
        else $error("trigger time-stamp not latched");
    chk_hiz_release: assert property (sync_mode != SYNC_OUT |-> sync_oe_n && !(sync_out
        && !sync_oe_n))
        else $error("sync pin driven outside output mode");
    chk_frac_range: assert property (trig_frac < FRAC_W'(INTERP_STEPS))
        else $error("interpolated fraction out of range");
    chk_gain_unity: assert property (in_valid && gain == GAIN_RESET
        && offset == signed'(OFFSET_RESET) |=> s.corr == $past(in_sample))
        else $error("unity gain changed a sample");
    chk_skip_gap: assert property (s.kept_v && skip == 16'h0001 && $stable(skip)
        |=> !s.kept_v)
        else $error("sample skip kept adjacent samples");
    chk_busy_ignore: assert property (s.state == ST_CAPTURE && hit
        |=> s.state != ST_DELAY && $stable(trig_ts))
        else $error("trigger accepted during capture");
    chk_count_stop: assert property (s.state == ST_CAPTURE && next_s.state == ST_ARMED
        |-> rec_count == 32'h0000_0000 || s.rec_left != 32'h0000_0001)
        else $error("record count exceeded");
endmodule : tta_acq_core

// [hdl/tta_pkg.sv]
package tta_pkg;
    // ----------------------------------------
    // datapath sizes
    // ----------------------------------------
    localparam int SAMPLE_W = 10;
    localparam int TS_W = 32;
    localparam int WORD_W = TS_W + 1;
    localparam int HDR_BIT = TS_W;
    localparam int FRAC_W = 8;
    localparam int TAPS = 4;
    localparam int COEF_W = 16;
    localparam int HIST_DEPTH = 64;
    localparam int FIFO_DEPTH = 32;
    // ----------------------------------------
    // correction
    // ----------------------------------------
    localparam int GAIN_FRAC = 14;
    localparam logic [15:0] GAIN_RESET = 16'h4000;
    localparam logic [15:0] OFFSET_RESET = 16'h0000;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int INTERP_RES_PS = 25;
    localparam int INTERP_STEPS = CLK_PERIOD_PS / INTERP_RES_PS;
    localparam int SYNC_PULSE_NS = 20;
    localparam int SYNC_PULSE_CYC = (SYNC_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // ----------------------------------------
    // modes and states
    // ----------------------------------------
    typedef enum logic [1:0] {
        TRIG_SW = 2'b00,
        TRIG_CHA = 2'b01,
        TRIG_STAR = 2'b10,
        TRIG_LEVEL = 2'b11
    } tta_trig_src_t;
    typedef enum logic [1:0] {
        SYNC_IN = 2'b00,
        SYNC_OUT = 2'b01,
        SYNC_HIZ = 2'b10
    } tta_sync_mode_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ARMED = 3'b001,
        ST_DELAY = 3'b010,
        ST_HDR_TS = 3'b011,
        ST_HDR_FR = 3'b100,
        ST_CAPTURE = 3'b101
    } tta_state_t;
endpackage : tta_pkg

// [hdl/tta_fifo.sv]
`timescale 1ns/1ps
module tta_fifo #(
    parameter int WIDTH = tta_pkg::WORD_W,
    parameter int DEPTH = tta_pkg::FIFO_DEPTH
) (
    // clocking
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    import tta_pkg::*;
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two");
    end

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } tta_fifo_state_t;

    tta_fifo_state_t s;
    tta_fifo_state_t next_s;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready = s.count != (AW+1)'(DEPTH);
    assign out_valid = s.count != '0;
    assign out_data = mem[s.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.wr = s.wr + 1'b1;
        end
        if (pop) begin
            next_s.rd = s.rd + 1'b1;
        end
        next_s.count = s.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    always_ff @(posedge clock) begin
        if (ce && push) begin
            mem[s.wr] <= in_data;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst || !ce);

    chk_fifo_full_stall: assert property (in_valid && !in_ready |=> s.wr == $past(s.wr))
        else $error("fifo took data while full");
    chk_fifo_count_step: assert property (push && !pop |=> s.count == $past(s.count) + 1'b1)
        else $error("fifo count did not follow a push");
endmodule : tta_fifo

// [verif/tta_host_sink.sv]
`timescale 1ns/1ps
// ----------------------------------------
// record sink standing in for the host
// ----------------------------------------
module tta_host_sink (
    // clocking
    input wire logic clock,
    input wire logic rst,
    // record stream
    input wire logic rec_valid,
    output logic rec_ready,
    input wire logic [tta_pkg::WORD_W-1:0] rec_data,
    // bench control
    input wire logic stall,
    input wire logic clr,
    output int n_words
);
    import tta_pkg::*;
    logic [WORD_W-1:0] words [0:63];
    assign rec_ready = !stall;
    always @(posedge clock) begin
        if (rst || clr) begin
            n_words <= 0;
        end else if (rec_valid && rec_ready) begin
            words[n_words[5:0]] <= rec_data;
            n_words <= n_words + 1;
        end
    end
endmodule : tta_host_sink

// [verif/trigger_timestamp_acquisition_tb.sv]
`timescale 1ns/1ps
`define CHK(what, exp, got) begin #1; checked++; if ((got) !== (exp)) begin n_fail++; \
    $display("wrong value %s exp %h got %h", what, exp, got); end @(posedge clock); end
// ----------------------------------------
// bench
// ----------------------------------------
module trigger_timestamp_acquisition_tb;
    import tta_pkg::*;
    logic clock = 0;
    logic rst = 1;
    logic signed [SAMPLE_W-1:0] samp = '0;
    logic signed [SAMPLE_W-1:0] thr = '0;
    logic [15:0] gain = GAIN_RESET;
    logic signed [15:0] offset = '0;
    logic [15:0] skip = '0;
    tta_trig_src_t trig_sel = TRIG_SW;
    tta_sync_mode_t sync_mode = SYNC_IN;
    logic fall = 0, sw_trig = 0, star_trig = 0, start = 0, stop = 0;
    logic sync_in = 0, stall = 0, clr = 0;
    logic [31:0] rec_len = 1, pre_len = 0, rec_count = 1, trig_delay = 0;
    logic sync_out, sync_oe_n, rec_valid, rec_ready, busy, done, overflow;
    logic [WORD_W-1:0] rec_data;
    logic [TS_W-1:0] timestamp, trig_ts, exp_ts;
    logic [TS_W-1:0] ts_ref = '0;
    logic [FRAC_W-1:0] trig_frac;
    int n_words, n;
    int checked = 0;
    int n_fail = 0;
    always #2.5 clock = ~clock;
    always @(posedge clock) ts_ref <= rst ? '0 : ts_ref + 1;
    tta_acq_core dut (.clock(clock), .rst(rst), .ce(1'b1), .in_valid(1'b1), .in_sample(samp),
        .cha_sample(samp), .gain(gain), .offset(offset), .skip(skip),
        .coef({16'h0000, 16'h0000, 16'h0000, 16'h4000}), .trig_sel(trig_sel),
        .trig_falling(fall), .level_thr(thr), .cha_thr(thr), .sw_trig(sw_trig),
        .star_trig(star_trig), .start(start), .stop(stop), .rec_len(rec_len),
        .pre_len(pre_len), .trig_delay(trig_delay), .rec_count(rec_count),
        .sync_mode(sync_mode), .sync_in(sync_in), .sync_out(sync_out), .sync_oe_n(sync_oe_n),
        .rec_valid(rec_valid), .rec_ready(rec_ready), .rec_data(rec_data), .busy(busy),
        .done(done), .overflow(overflow), .timestamp(timestamp), .trig_ts(trig_ts),
        .trig_frac(trig_frac));
    tta_host_sink host (.clock(clock), .rst(rst), .rec_valid(rec_valid),
        .rec_ready(rec_ready), .rec_data(rec_data), .stall(stall), .clr(clr),
        .n_words(n_words));
    task automatic tick(input int k);
        repeat (k) @(posedge clock);
    endtask : tick
    task automatic arm();
        clr <= 1;
        start <= 1;
        tick(1);
        clr <= 0;
        start <= 0;
        tick(2);
        `CHK("busy", 1'b1, busy)
    endtask : arm
    task automatic wait_done();
        n = 0;
        while (done !== 1'b1 && n < 500) begin
            tick(1);
            n++;
        end
        `CHK("done", 1'b1, done)
        tick(60);
    endtask : wait_done
    task automatic t_soft();
        rec_len <= 40;
        sync_mode <= SYNC_OUT;
        stall <= 1;
        arm();
        @(posedge clock);
        sw_trig <= 1;
        #1 exp_ts = ts_ref;
        @(posedge clock);
        sw_trig <= 0;
        n = 0;
        repeat (8) begin
            #1 n += int'(sync_out);
            @(posedge clock);
        end
        `CHK("sync pulse", SYNC_PULSE_CYC, n)
        `CHK("sync drive", 1'b0, sync_oe_n)
        tick(40);
        `CHK("stalled valid", 1'b1, rec_valid)
        `CHK("stalled words", 0, n_words)
        `CHK("trig ts", exp_ts, trig_ts)
        stall <= 0;
        wait_done();
        `CHK("word count", 42, n_words)
        `CHK("header", {1'b1, exp_ts}, host.words[0])
        `CHK("done", 1'b1, done)
        `CHK("overflow", 1'b0, overflow)
    endtask : t_soft
    task automatic t_ignore();
        rec_len <= 1;
        arm();
        star_trig <= 1;
        tick(4);
        star_trig <= 0;
        tick(4);
        `CHK("unselected words", 0, n_words)
        stop <= 1;
        tick(1);
        stop <= 0;
        tick(2);
        `CHK("stopped", 1'b0, busy)
        trig_sel <= TRIG_STAR;
        arm();
        star_trig <= 1;
        tick(2);
        star_trig <= 0;
        wait_done();
        `CHK("star record", 3, n_words)
    endtask : t_ignore
    task automatic t_level(input logic f, input logic signed [SAMPLE_W-1:0] a, b);
        logic signed [SAMPLE_W-1:0] ea;
        logic signed [SAMPLE_W-1:0] eb;
        ea = SAMPLE_W'(a * 2);
        eb = SAMPLE_W'(b * 2);
        trig_sel <= TRIG_LEVEL;
        fall <= f;
        thr <= 10'sd150;
        gain <= 16'h8000;
        rec_len <= 8;
        pre_len <= 4;
        samp <= a;
        tick(80);
        arm();
        samp <= b;
        wait_done();
        `CHK("level words", 10, n_words)
        `CHK("pre sample", {1'b0, 32'(ea)}, host.words[2])
        `CHK("post sample", {1'b0, 32'(eb)}, host.words[9])
    endtask : t_level
    task automatic t_cha(input int d, input int skp);
        trig_sel <= TRIG_CHA;
        fall <= 0;
        thr <= 10'sd50;
        gain <= GAIN_RESET;
        rec_len <= 1;
        pre_len <= 0;
        trig_delay <= d;
        skip <= 16'(skp);
        samp <= '0;
        tick(4);
        arm();
        samp <= 10'sd100;
        n = 0;
        while (rec_valid !== 1'b1 && n < 40) begin
            tick(1);
            #1 n++;
        end
        `CHK("delay cycles", d, (n - 2 + skp) / (skp + 1))
        wait_done();
        `CHK("cha frac", FRAC_W'(50 * INTERP_STEPS / 100), trig_frac)
        `CHK("cha words", 3, n_words)
    endtask : t_cha
    task automatic t_sync();
        sync_mode <= SYNC_HIZ;
        tick(2);
        `CHK("released", 1'b1, sync_oe_n)
        sync_mode <= SYNC_IN;
        tick(2);
        `CHK("input oe", 1'b1, sync_oe_n)
        sync_in <= 1;
        tick(4);
        `CHK("ts cleared", 32'd3, timestamp)
    endtask : t_sync
    task automatic wrap_up();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        tick(10);
        rst <= 0;
        tick(2);
        t_soft();
        t_ignore();
        t_level(1'b0, 10'sd0, 10'sd100);
        t_level(1'b1, 10'sd100, 10'sd0);
        t_cha(5, 0);
        t_cha(4, 1);
        t_sync();
        wrap_up();
    end
    initial begin
        #20000;
        n_fail++;
        wrap_up();
    end
endmodule : trigger_timestamp_acquisition_tb
